/* File: core/dcts_pkg.sv */
// Constants for the delayed control transfer sequencer.
// Assumes a 32-bit instruction word and eight register windows.
package dcts_pkg;
  // Register map, byte addresses on the AXI4-Lite slave
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_START  = 8'h04;
  localparam logic [7:0] ADDR_WIM    = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_PC     = 8'h10;
  localparam logic [7:0] ADDR_NPC    = 8'h14;
  localparam logic [7:0] ADDR_CWP    = 8'h18;

  // Control fields
  localparam int CTRL_RUN_BIT  = 0;
  localparam int CTRL_LOAD_BIT = 1;
  // Status fields
  localparam int ST_CWP_LSB    = 0;
  localparam int ST_ANNUL_BIT  = 4;
  localparam int ST_RUN_BIT    = 5;
  localparam int ST_OVF_BIT    = 8;
  localparam int ST_UNF_BIT    = 9;
  localparam int ST_TRAP_BIT   = 10;

  // Reset values
  localparam logic [31:0] START_RST = 32'h0000_0000;
  localparam logic [7:0]  WIM_RST   = 8'h00;
  localparam logic [2:0]  CWP_RST   = 3'h0;

  // Windowed register file geometry
  localparam int          NWIN      = 8;
  localparam int          CWP_W     = 3;
  localparam int          PHYS_W    = 8;
  localparam logic [4:0]  LINK_REG  = 5'h0F;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;

  // Instruction field encodings
  localparam logic [1:0] OP_FMT2    = 2'h0;
  localparam logic [1:0] OP_CALL    = 2'h1;
  localparam logic [1:0] OP_FMT3    = 2'h2;
  localparam logic [2:0] OP2_ICC_BR = 3'h2;
  localparam logic [2:0] OP2_FCC_BR = 3'h6;
  localparam logic [2:0] OP2_CCC_BR = 3'h7;
  localparam logic [5:0] OP3_JUMP_AND_LINK_INDIRECT   = 6'h38;
  localparam logic [5:0] OP3_TICC   = 6'h3A;
  localparam logic [5:0] OP3_SAVE   = 6'h3C;
  localparam logic [5:0] OP3_REST   = 6'h3D;
  localparam logic [3:0] COND_NEVER = 4'h0;
  localparam logic [3:0] COND_ALWAYS = 4'h8;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: core/dcts_seq.sv */
// Program-counter sequencer: call/link, window save/restore, delayed
// transfers with annul handling, plus an AXI4-Lite control slave.
// Assumes fetch returns the word at fetch_addr, operands come from the
// current window, and condition results are evaluated outside.
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// What this block does
// - Call target reaches any address via 30-bit displacement added to PC.
// - Indirect jump target is rs1 plus rs2 or sign-extended 13-bit immediate.
// - Call writes its own PC into out register 15 of current window.
// - Out register 15 maps onto in register 31 of the next window.
// - Indirect jump writes its own PC into destination register rd.
// - Save decrements current window pointer by one.
// - Save adds caller-window operands, writes sum into new window.
// - Restore increments current window pointer by one.
// - Restore adds called-window operands, writes sum into caller window.
// - Save and restore check new pointer against invalid window mask.
// - Delay instruction executes before the transfer target.
// - Next PC holds PC plus 4 without transfer or trap.
// - Each instruction but a taken trap or a faulting save/restore copies next PC to PC, then steps or loads target.
// - Transfer in a delay slot takes earlier target as its delay instruction.
// - Annul bit honoured only in the three conditional branch kinds.
// - Untaken conditional branch with annul set annuls the delay instruction.
// - Annulled instruction changes no state and never traps.
// - Taken conditional branch ignores annul and executes delay instruction.
// - Branch-always with annul set annuls delay instruction yet branches.
// - Annul clear: every branch executes its delay instruction.
// - Taken branch target is own address plus 4 times displacement.
// - Branch-never never transfers but annuls when annul bit set.
// - Taken trap transfers at once with no delay instruction.
module dcts_seq (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [7:0]                 s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Instruction fetch
  output logic [31:0]                     fetch_addr,
  input  wire logic [31:0]                instr,
  input  wire logic                       instr_valid,
  output logic                            instr_ready,
  // Condition results for the instruction now presented
  input  wire logic                       icc_true,
  input  wire logic                       fcc_true,
  input  wire logic                       ccc_true,
  input  wire logic [31:0]                trap_target,
  // Register file
  input  wire logic [31:0]                rs1_val,
  input  wire logic [31:0]                rs2_val,
  output logic [dcts_pkg::PHYS_W-1:0]     rs1_phys,
  output logic [dcts_pkg::PHYS_W-1:0]     rs2_phys,
  output logic                            rf_we,
  output logic [dcts_pkg::PHYS_W-1:0]     rf_waddr,
  output logic [31:0]                     rf_wdata,
  // Events
  output logic                            window_overflow,
  output logic                            window_underflow,
  output logic                            trap_taken
);

  // Window-relative register to physical slot; outs alias next window ins
  function automatic logic [dcts_pkg::PHYS_W-1:0] phys_reg(
    input logic [dcts_pkg::CWP_W-1:0] win,
    input logic [4:0]                 r);
    logic [dcts_pkg::CWP_W-1:0] w;
    w = win;
    if (r[4:3] == 2'h0) begin
      phys_reg = {3'h0, r};
    end else begin
      if (r[4:3] == 2'h1) begin
        w = win - 3'h1;
      end
      phys_reg = 8'h08 + {1'b0, w, 4'h0} + {4'h0, r[4] & ~r[3], r[2:0]};
    end
  endfunction

  // Pointer step with wrap over the implemented windows
  function automatic logic [dcts_pkg::CWP_W-1:0] win_step(
    input logic [dcts_pkg::CWP_W-1:0] win,
    input logic                       up);
    logic [3:0] t;
    t = up ? {1'b0, win} + 4'h1 : {1'b0, win} + 4'(dcts_pkg::NWIN - 1);
    win_step = 3'(t % 4'(dcts_pkg::NWIN));
  endfunction

  logic [31:0] pc_r;
  logic [31:0] npc_r;
  logic [2:0]  cwp_r;
  logic        annul_r;
  logic        run_r;
  logic [31:0] start_r;
  logic [7:0]  wim_r;
  logic        ovf_r;
  logic        unf_r;
  logic        trp_r;
  logic        load_pulse;

  // Decode
  logic [1:0]  op;
  logic [2:0]  op2;
  logic [5:0]  op3;
  logic [3:0]  cond;
  logic [4:0]  rd;
  logic        abit;
  logic        is_call;
  logic        is_br;
  logic        is_jump_and_link_indirect;
  logic        is_save;
  logic        is_rest;
  logic        is_ticc;
  logic        ctrue;
  logic        br_taken;
  logic        annul_nxt;
  logic [31:0] opnd_b;
  logic [31:0] sum;
  logic [31:0] target;
  logic [2:0]  cwp_nxt;
  logic        win_fault;
  logic        trap_go;
  logic        fire;
  logic        exec;

  assign op    = instr[31:30];
  assign op2   = instr[24:22];
  assign op3   = instr[24:19];
  assign cond  = instr[28:25];
  assign rd    = instr[29:25];
  assign abit  = instr[29];

  assign is_call = (op == dcts_pkg::OP_CALL);
  assign is_br   = (op == dcts_pkg::OP_FMT2) &&
                   (op2 == dcts_pkg::OP2_ICC_BR || op2 == dcts_pkg::OP2_FCC_BR ||
                    op2 == dcts_pkg::OP2_CCC_BR);
  assign is_jump_and_link_indirect = (op == dcts_pkg::OP_FMT3) && (op3 == dcts_pkg::OP3_JUMP_AND_LINK_INDIRECT);
  assign is_save = (op == dcts_pkg::OP_FMT3) && (op3 == dcts_pkg::OP3_SAVE);
  assign is_rest = (op == dcts_pkg::OP_FMT3) && (op3 == dcts_pkg::OP3_REST);
  assign is_ticc = (op == dcts_pkg::OP_FMT3) && (op3 == dcts_pkg::OP3_TICC);

  always_comb begin
    case (op2)
      dcts_pkg::OP2_FCC_BR: ctrue = fcc_true;
      dcts_pkg::OP2_CCC_BR: ctrue = ccc_true;
      default:              ctrue = icc_true;
    endcase
    if (cond == dcts_pkg::COND_ALWAYS) begin
      ctrue = 1'b1;
    end else if (cond == dcts_pkg::COND_NEVER) begin
      ctrue = 1'b0;
    end
  end

  assign br_taken  = is_br && ctrue;
  // Always-form annuls though taken; others only when untaken
  assign annul_nxt = is_br && abit &&
                     ((cond == dcts_pkg::COND_ALWAYS) || !br_taken);

  assign opnd_b = instr[13] ? {{19{instr[12]}}, instr[12:0]} : rs2_val;
  assign sum    = rs1_val + opnd_b;

  always_comb begin
    if (is_call) begin
      target = pc_r + {instr[29:0], 2'h0};
    end else if (is_jump_and_link_indirect) begin
      target = sum;
    end else begin
      target = pc_r + {{8{instr[21]}}, instr[21:0], 2'h0};
    end
  end

  assign cwp_nxt   = win_step(cwp_r, is_rest);
  assign win_fault = (is_save || is_rest) && wim_r[cwp_nxt];
  assign trap_go   = is_ticc && ((cond == dcts_pkg::COND_ALWAYS) ||
                     ((cond != dcts_pkg::COND_NEVER) && icc_true));

  assign instr_ready = run_r;
  assign fire        = instr_valid && run_r;
  // Annulled slot is consumed with no effect at all
  assign exec        = fire && !annul_r;
  assign fetch_addr  = pc_r;
  assign rs1_phys    = phys_reg(cwp_r, instr[18:14]);
  assign rs2_phys    = phys_reg(cwp_r, instr[4:0]);

  // Program counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_r  <= dcts_pkg::START_RST;
      npc_r <= dcts_pkg::START_RST + dcts_pkg::WORD_STEP;
    end else if (load_pulse) begin
      pc_r  <= start_r;
      npc_r <= start_r + dcts_pkg::WORD_STEP;
    end else if (exec && trap_go) begin
      pc_r  <= trap_target;
      npc_r <= trap_target + dcts_pkg::WORD_STEP;
    end else if (fire && !(exec && win_fault)) begin
      pc_r <= npc_r;
      if (exec && (is_call || is_jump_and_link_indirect || br_taken)) begin
        npc_r <= target;
      end else begin
        npc_r <= npc_r + dcts_pkg::WORD_STEP;
      end
    end
  end

  // Annul flag for the next instruction consumed
  always_ff @(posedge aclk) begin
    if (!aresetn || load_pulse) begin
      annul_r <= 1'b0;
    end else if (fire) begin
      annul_r <= exec && !trap_go && annul_nxt;
    end
  end

  // Window pointer; CURRENT_WINDOW_POINTER register write from the bus has lower priority
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cwp_r <= dcts_pkg::CWP_RST;
    end else if (exec && (is_save || is_rest) && !win_fault) begin
      cwp_r <= cwp_nxt;
    end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
                 s_axi_awaddr == dcts_pkg::ADDR_CWP && s_axi_wstrb[0]) begin
      cwp_r <= s_axi_wdata[2:0];
    end
  end

  // Register file write port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rf_we    <= 1'b0;
      rf_waddr <= '0;
      rf_wdata <= '0;
    end else begin
      rf_we <= 1'b0;
      if (exec && !trap_go && !win_fault) begin
        if (is_call) begin
          rf_we    <= 1'b1;
          rf_waddr <= phys_reg(cwp_r, dcts_pkg::LINK_REG);
          rf_wdata <= pc_r;
        end else if (is_jump_and_link_indirect) begin
          rf_we    <= (rd != 5'h00);
          rf_waddr <= phys_reg(cwp_r, rd);
          rf_wdata <= pc_r;
        end else if (is_save || is_rest) begin
          rf_we    <= (rd != 5'h00);
          rf_waddr <= phys_reg(cwp_nxt, rd);
          rf_wdata <= sum;
        end
      end
    end
  end

  // Event pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      window_overflow  <= 1'b0;
      window_underflow <= 1'b0;
      trap_taken       <= 1'b0;
    end else begin
      window_overflow  <= exec && is_save && win_fault;
      window_underflow <= exec && is_rest && win_fault;
      trap_taken       <= exec && trap_go;
    end
  end

  // AXI4-Lite write side: address and data taken together
  logic       wr_go;
  logic [1:0] wr_resp;
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;

  always_comb begin
    case (s_axi_awaddr)
      dcts_pkg::ADDR_CTRL, dcts_pkg::ADDR_START, dcts_pkg::ADDR_WIM,
      dcts_pkg::ADDR_STATUS, dcts_pkg::ADDR_CWP: wr_resp = dcts_pkg::RESP_OKAY;
      dcts_pkg::ADDR_PC, dcts_pkg::ADDR_NPC:     wr_resp = dcts_pkg::RESP_OKAY;
      default:                                   wr_resp = dcts_pkg::RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dcts_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_resp;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign load_pulse = wr_go && s_axi_awaddr == dcts_pkg::ADDR_CTRL && s_axi_wstrb[0] &&
                      s_axi_wdata[dcts_pkg::CTRL_LOAD_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_r <= dcts_pkg::START_RST;
      wim_r   <= dcts_pkg::WIM_RST;
    end else if (wr_go) begin
      if (s_axi_awaddr == dcts_pkg::ADDR_START) begin
        for (int b = 0; b < 4; b++) begin
          if (s_axi_wstrb[b]) begin
            start_r[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
          end
        end
      end
      if (s_axi_awaddr == dcts_pkg::ADDR_WIM && s_axi_wstrb[0]) begin
        wim_r <= s_axi_wdata[7:0];
      end
    end
  end

  // Run stops on a window fault so software can spill or fill first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_r <= 1'b0;
    end else if (exec && win_fault) begin
      run_r <= 1'b0;
    end else if (wr_go && s_axi_awaddr == dcts_pkg::ADDR_CTRL && s_axi_wstrb[0]) begin
      run_r <= s_axi_wdata[dcts_pkg::CTRL_RUN_BIT];
    end
  end

  // Sticky flags, write one to clear; a new event wins over the clear
  logic st_clr;
  assign st_clr = wr_go && s_axi_awaddr == dcts_pkg::ADDR_STATUS && s_axi_wstrb[1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_r <= 1'b0;
      unf_r <= 1'b0;
      trp_r <= 1'b0;
    end else begin
      ovf_r <= (exec && is_save && win_fault) ||
               (ovf_r && !(st_clr && s_axi_wdata[dcts_pkg::ST_OVF_BIT]));
      unf_r <= (exec && is_rest && win_fault) ||
               (unf_r && !(st_clr && s_axi_wdata[dcts_pkg::ST_UNF_BIT]));
      trp_r <= (exec && trap_go) ||
               (trp_r && !(st_clr && s_axi_wdata[dcts_pkg::ST_TRAP_BIT]));
    end
  end

  // AXI4-Lite read side
  logic [31:0] rd_data;
  logic [1:0]  rd_resp;
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_resp = dcts_pkg::RESP_OKAY;
    case (s_axi_araddr)
      dcts_pkg::ADDR_CTRL:   rd_data[dcts_pkg::CTRL_RUN_BIT] = run_r;
      dcts_pkg::ADDR_START:  rd_data = start_r;
      dcts_pkg::ADDR_WIM:    rd_data[7:0] = wim_r;
      dcts_pkg::ADDR_STATUS: begin
        rd_data[dcts_pkg::ST_CWP_LSB +: 3] = cwp_r;
        rd_data[dcts_pkg::ST_ANNUL_BIT]    = annul_r;
        rd_data[dcts_pkg::ST_RUN_BIT]      = run_r;
        rd_data[dcts_pkg::ST_OVF_BIT]      = ovf_r;
        rd_data[dcts_pkg::ST_UNF_BIT]      = unf_r;
        rd_data[dcts_pkg::ST_TRAP_BIT]     = trp_r;
      end
      dcts_pkg::ADDR_PC:     rd_data = pc_r;
      dcts_pkg::ADDR_NPC:    rd_data = npc_r;
      dcts_pkg::ADDR_CWP:    rd_data[2:0] = cwp_r;
      default:               rd_resp = dcts_pkg::RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= dcts_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_resp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  a_npc_step: assert property (@(posedge aclk) disable iff (!aresetn)
    (exec && !load_pulse && !trap_go && !win_fault && !is_call && !is_jump_and_link_indirect && !br_taken)
    |=> npc_r == $past(npc_r) + 32'h0000_0004)
    else $error("next PC did not step by four");

  a_pc_copy: assert property (@(posedge aclk) disable iff (!aresetn)
    (fire && !load_pulse && !(exec && (trap_go || win_fault))) |=> pc_r == $past(npc_r))
    else $error("PC did not take next PC");

  a_call_link: assert property (@(posedge aclk) disable iff (!aresetn)
    (exec && is_call && !load_pulse) |=> rf_we && rf_wdata == $past(pc_r) &&
    rf_waddr == phys_reg($past(cwp_r), 5'h0F))
    else $error("call link not written to out register 15");

  a_annul_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (exec && is_br && abit && !ctrue && !load_pulse) |=> annul_r)
    else $error("untaken annulling branch left delay slot live");

  a_annul_skip: assert property (@(posedge aclk) disable iff (!aresetn)
    (fire && annul_r) |=> !rf_we && !trap_taken && $stable(cwp_r))
    else $error("annulled instruction changed state");

  a_taken_noannul: assert property (@(posedge aclk) disable iff (!aresetn)
    (exec && br_taken && cond != 4'h8 && !load_pulse) |=> !annul_r)
    else $error("taken branch annulled its delay slot");

  a_save_cwp: assert property (@(posedge aclk) disable iff (!aresetn)
    (exec && is_save && !win_fault) |=> cwp_r == 3'($past(cwp_r) - 3'h1))
    else $error("save did not decrement window pointer");

  a_ovf_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (exec && is_save && win_fault) |=> window_overflow && $stable(cwp_r) && !run_r)
    else $error("overflow not flagged or pointer moved");

  a_trap_now: assert property (@(posedge aclk) disable iff (!aresetn)
    (exec && trap_go && !load_pulse) |=> pc_r == $past(trap_target) && !annul_r)
    else $error("trap did not transfer at once");

endmodule

/* File: tb/dcts_imem.sv */
// Instruction memory model on the fetch side of the sequencer.
// Assumes word addresses below 256 bytes; the bench preloads mem.
`timescale 1ns/1ps
module dcts_imem (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        slow,
  input  wire logic [31:0] fetch_addr,
  input  wire logic        instr_ready,
  output logic [31:0]      instr,
  output logic             instr_valid
);
  logic [31:0] mem [64];
  logic [31:0] last_r;
  logic        gap_r;
  // Slow mode drops valid every other cycle, like a waiting memory
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_r <= 1'b0;
    end else begin
      gap_r <= slow & ~gap_r;
    end
  end
  always_ff @(posedge aclk) begin
    last_r <= instr;
  end
  // No word offered: show the inverse so a stale value never passes
  always_comb begin
    instr_valid = aresetn & ~gap_r;
    instr       = instr_valid ? mem[fetch_addr[7:2]] : ~last_r;
  end
endmodule

/* File: tb/delayed_control_transfer_seq_tb.sv */
// Bench for the sequencer: AXI4-Lite setup, then one program run.
// Assumes dcts_imem as fetch partner and a register file kept here.
`timescale 1ns/1ps
module delayed_control_transfer_seq_tb;
  logic aclk, aresetn, awv, wv, bry, arv, rry, slow;
  logic awr, wr, bv, arr, rv, ir, iv, we, ovf, unf, trp;
  logic [7:0] awa, ara, rp1, rp2, wa;
  logic [31:0] wd, rd, fa, ins, wdat, rf [256];
  logic [1:0] br, rr;
  logic [31:0] trace [$];
  logic [39:0] wlog [$];
  int n_fail, cmp_count;
  localparam logic [31:0] EXP_PC [15] = '{32'h00, 32'h04, 32'h20, 32'h24, 32'h28,
    32'h2C, 32'h38, 32'h3C, 32'h40, 32'h44, 32'h50, 32'h54, 32'h58, 32'h08, 32'h64};
  dcts_seq dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .fetch_addr(fa),
    .instr(ins), .instr_valid(iv), .instr_ready(ir), .icc_true(1'b0), .fcc_true(1'b1),
    .ccc_true(1'b0), .trap_target(32'h0000_0064), .rs1_val(rf[rp1]), .rs2_val(rf[rp2]),
    .rs1_phys(rp1), .rs2_phys(rp2), .rf_we(we), .rf_waddr(wa), .rf_wdata(wdat),
    .window_overflow(ovf), .window_underflow(unf), .trap_taken(trp));
  dcts_imem imem (.aclk(aclk), .aresetn(aresetn), .slow(slow), .fetch_addr(fa),
    .instr_ready(ir), .instr(ins), .instr_valid(iv));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Register file and trace of consumed fetches and writes
  always @(posedge aclk) begin
    if (aresetn && iv && ir) trace.push_back(fa);
    if (we) begin
      rf[wa] <= wdat;
      wlog.push_back({wa, wdat});
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bry <= 1'b1;
    do @(posedge aclk); while (awr !== 1'b1 && ++n < 100);
    awv <= 1'b0;
    wv  <= 1'b0;
    do @(posedge aclk); while (bv !== 1'b1 && ++n < 100);
    r = br;
    bry <= 1'b0;
    if (n >= 100) n_fail++;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge aclk); while (arr !== 1'b1 && ++n < 100);
    arv <= 1'b0;
    do @(posedge aclk); while (rv !== 1'b1 && ++n < 100);
    d = rd;
    r = rr;
    rry <= 1'b0;
    if (n >= 100) n_fail++;
  endtask
  task automatic test_reset_regs();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(dcts_pkg::ADDR_PC, d, r);
    chk(d, 32'h0000_0000);
    axi_rd(dcts_pkg::ADDR_NPC, d, r);
    chk(d, 32'h0000_0004);
    axi_wr(dcts_pkg::ADDR_PC, 32'h0000_0040, r);
    axi_rd(dcts_pkg::ADDR_PC, d, r);
    chk(d, 32'h0000_0000);
    axi_rd(8'h3C, d, r);
    chk({30'h0, r}, {30'h0, dcts_pkg::RESP_SLVERR});
  endtask
  // Call, annulled slots, branches, window ops, return, trap, overflow
  task automatic test_program();
    logic [31:0] d;
    logic [1:0]  r;
    int n;
    for (int i = 0; i < 64; i++) imem.mem[i] = 32'h0080_0000;
    imem.mem[0]  = 32'h4000_0008;
    imem.mem[8]  = 32'h20800000;
    imem.mem[9]  = 32'h4000_0010;
    imem.mem[10] = 32'h3080_0004;
    imem.mem[11] = 32'h4000_0010;
    imem.mem[14] = 32'h23C0_0004;
    imem.mem[15] = 32'h4000_0010;
    imem.mem[16] = 32'h2380_0004;
    // Restore then save keeps both clear of the masked window
    imem.mem[17] = 32'h81E8_2000;
    imem.mem[20] = 32'h81E0_2000;
    imem.mem[21] = 32'h83C3_E008;
    imem.mem[2]  = 32'h91D0_2000;
    imem.mem[25] = 32'h81E0_2000;
    slow <= 1'b1;
    axi_wr(dcts_pkg::ADDR_WIM, 32'h0000_0080, r);
    axi_wr(dcts_pkg::ADDR_START, 32'h0000_0000, r);
    axi_wr(dcts_pkg::ADDR_CTRL, 32'h0000_0003, r);
    repeat (3) @(posedge aclk);
    n = 0;
    while (ir !== 1'b0 && n < 400) begin
      @(posedge aclk);
      n++;
    end
    chk({31'h0, ir}, 32'h0000_0000);
    chk(trace.size(), 15);
    for (int i = 0; i < 15; i++) chk(trace[i], EXP_PC[i]);
    chk(wlog.size(), 2);
    chk(wlog[0][39:32], 8'h7F);
    chk(wlog[0][31:0], 32'h0000_0000);
    chk(wlog[1], {8'h01, 32'h0000_0054});
    axi_rd(dcts_pkg::ADDR_STATUS, d, r);
    chk(d[10:8], 3'b101);
    chk({d[5], d[2:0]}, 4'h0);
    axi_rd(dcts_pkg::ADDR_PC, d, r);
    chk(d, 32'h0000_0064);
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    aresetn = 1'b0;
    {awv, wv, bry, arv, rry, slow} = '0;
    awa = '0;
    ara = '0;
    wd  = '0;
    for (int i = 0; i < 256; i++) rf[i] = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    test_reset_regs();
    test_program();
    stop_test();
  end
  // Run takes well under a thousand cycles
  initial begin
    #100us;
    n_fail++;
    stop_test();
  end
endmodule
